// [logic/pclk_defines.vh]
// constants and register layout for the pll clock reset and lock control block
`ifndef PCLK_DEFINES_VH
`define PCLK_DEFINES_VH
`define PCLK_ADR_CTRL 32'h8007fc50
`define PCLK_ADR_STAT 32'h8007fc54
// bit numbers below are lsb-0 positions (31 - msb-0 number)
`define PCLK_B_WAKE_MASK 28
`define PCLK_B_DEC_GATE 26
`define PCLK_B_LOLRST_EN 25
`define PCLK_B_OSCRST_EN 24
`define PCLK_F_MULT_HI 22
`define PCLK_F_MULT_LO 19
`define PCLK_F_PMODE_HI 9
`define PCLK_F_PMODE_LO 8
`define PCLK_F_PRESC_HI 3
`define PCLK_F_PRESC_LO 0
`define PCLK_B_TEST_EN 27
`define PCLK_B_MULT_LOCK 26
`define PCLK_B_PMODE_LOCK 25
`define PCLK_B_PRESC_LOCK 24
`define PCLK_F_TSEL_HI 17
`define PCLK_F_TSEL_LO 16
`define PCLK_B_WAKE_REQ 8
`define PCLK_B_STICKY 2
`define PCLK_B_LOCKED 1
`define PCLK_B_OSC_MISS 0
`define PCLK_CTRL_RST 32'h00000000
`define PCLK_CTRL_DEC_RST 1'b1
`define PCLK_MULT_RST 4'h1
`define PCLK_PRESC_RST 4'h0
`define PCLK_PMODE_RST 2'h0
`define PCLK_PRESC_MAX 4'h9
`define PCLK_PRESC_SAT 4'ha
`define PCLK_MULT_BASE 4'h4
`endif

// [logic/pclk_ctrl.v]
// clock register pair, clock reset generation and clock-control outputs
`timescale 1ns/1ps
`include "pclk_defines.vh"
module pclk_ctrl (
    input wire REF_CLK, // 250 MHz system clock
    input wire NRST, // async reset, active low (keep-alive power-on)
    input wire EXT_RESET, // external reset request, active high
    input wire PLL_LOCKED, // pll lock indication
    input wire OSC_LOST, // oscillator detector: high below 125 kHz, low above 500 kHz
    input wire PLL_BYPASS, // pll bypass strap
    input wire ONE_TO_ONE, // one-to-one clock mode strap
    input wire FREEZE, // debug freeze mode
    input wire DEC_MSB, // decrementer most significant bit
    input wire IRQ_WAKE, // external interrupt pin wake request, active high
    input wire [31:0] WB_ADR_I, // wishbone address
    input wire [31:0] WB_DAT_I, // wishbone write data
    input wire [3:0] WB_SEL_I, // wishbone byte selects
    input wire WB_WE_I, // wishbone write enable
    input wire WB_CYC_I, // wishbone cycle
    input wire WB_STB_I, // wishbone strobe
    output reg [31:0] WB_DAT_O, // wishbone read data
    output reg WB_ACK_O, // wishbone acknowledge
    output reg WB_ERR_O, // wishbone error on unmapped address
    output reg CLOCK_RESET, // internal clock reset, active high
    output reg POWER_DOWN_WAKE_OUTPUT, // external supply wake request
    output reg SELF_CLOCKED_MODE, // pll forced into self-clocked mode
    output reg DECREMENTER_CLOCK_GATE, // decrementer clock enable
    output reg WAKE_PIN_EXIT, // masked interrupt wake toward exit logic
    output reg [3:0] FEEDBACK_DIVIDE, // pll feedback divider, 4..11
    output reg [3:0] PRESCALE_LOG2, // output divide as power of two, 0..10
    output reg [1:0] POWER_MODE_SELECT // 00 normal, 01 single chip, 10 doze, 11 sleep
);
    // control register fields
    reg wake_pin_mask_q;
    reg decrementer_clock_gate_q;
    reg lock_loss_reset_enable_q;
    reg osc_loss_reset_enable_q;
    reg [3:0] multiplication_factor_q;
    reg [1:0] power_mode_select_q;
    reg [3:0] output_prescaler_q;
    // status register fields
    reg pll_test_enable_q;
    reg multiplier_write_lock_q;
    reg power_mode_write_lock_q;
    reg prescaler_write_lock_q;
    reg [1:0] pll_test_select_q;
    reg wake_request_q;
    reg pll_lock_sticky_q;
    reg test_lock_q;
    reg test_osc_q;
    reg dec_msb_q;
    reg clk_rst_q;
    wire test_mode;
    wire locked_view;
    wire osc_view;
    wire lock_loss;
    wire clk_rst_d;
    wire req;
    wire wr;
    wire hit_ctrl;
    wire hit_stat;
    wire [31:0] ctrl_rd;
    wire [31:0] stat_rd;
    wire [31:0] wmask;
    wire dec_rise;

    // expand byte selects into a bit mask
    function [31:0] sel_mask;
        input [3:0] sel;
        begin
            sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        end
    endfunction

    // merge written bits under mask into a current value
    function merge_bit;
        input cur;
        input newv;
        input m;
        begin
            merge_bit = m ? newv : cur;
        end
    endfunction

    assign test_mode = pll_test_enable_q;
    assign osc_view = test_mode ? test_osc_q : OSC_LOST;
    // bypass/test force a locked report; lost oscillator drops lock
    assign locked_view = (PLL_BYPASS || test_mode) ? 1'b1 :
        (test_mode ? test_lock_q : (PLL_LOCKED && !osc_view));
    // in bypass/test the pll is off, so the raw loss request fires if enabled
    assign lock_loss = (PLL_BYPASS || test_mode) ? 1'b1 : !locked_view;
    assign clk_rst_d = EXT_RESET || (osc_view && osc_loss_reset_enable_q) ||
        (lock_loss && lock_loss_reset_enable_q) ||
        (clk_rst_q && !locked_view && !EXT_RESET && !PLL_BYPASS && !test_mode);
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
    assign hit_ctrl = (WB_ADR_I == `PCLK_ADR_CTRL);
    assign hit_stat = (WB_ADR_I == `PCLK_ADR_STAT);
    assign wr = req && WB_WE_I;
    assign wmask = sel_mask(WB_SEL_I);
    assign dec_rise = DEC_MSB && !dec_msb_q;

    // reserved bits assemble as zero
    assign ctrl_rd = {3'h0, wake_pin_mask_q, 1'b0, decrementer_clock_gate_q, lock_loss_reset_enable_q,
        osc_loss_reset_enable_q, 1'b0, multiplication_factor_q, 9'h000, power_mode_select_q, 4'h0,
        output_prescaler_q};
    assign stat_rd = {4'h0, pll_test_enable_q, multiplier_write_lock_q, power_mode_write_lock_q,
        prescaler_write_lock_q, 6'h00, pll_test_select_q, 7'h00, wake_request_q, 5'h00,
        pll_lock_sticky_q, locked_view, osc_view};

    // decrementer edge detector and the clock reset flop live on keep-alive reset only
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            dec_msb_q <= 1'b0;
            clk_rst_q <= 1'b1;
        end else begin
            dec_msb_q <= DEC_MSB;
            clk_rst_q <= clk_rst_d;
        end
    end

    // control register: back to reset values on clock reset, locks gate field writes
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wake_pin_mask_q <= 1'b0;
            decrementer_clock_gate_q <= `PCLK_CTRL_DEC_RST;
            lock_loss_reset_enable_q <= 1'b0;
            osc_loss_reset_enable_q <= 1'b0;
            multiplication_factor_q <= `PCLK_MULT_RST;
            power_mode_select_q <= `PCLK_PMODE_RST;
            output_prescaler_q <= `PCLK_PRESC_RST;
        end else if (clk_rst_q) begin
            wake_pin_mask_q <= 1'b0;
            decrementer_clock_gate_q <= `PCLK_CTRL_DEC_RST;
            lock_loss_reset_enable_q <= 1'b0;
            osc_loss_reset_enable_q <= 1'b0;
            multiplication_factor_q <= `PCLK_MULT_RST;
            power_mode_select_q <= `PCLK_PMODE_RST;
            output_prescaler_q <= `PCLK_PRESC_RST;
        end else if (wr && hit_ctrl) begin
            wake_pin_mask_q <= merge_bit(wake_pin_mask_q, WB_DAT_I[`PCLK_B_WAKE_MASK],
                wmask[`PCLK_B_WAKE_MASK]);
            decrementer_clock_gate_q <= merge_bit(decrementer_clock_gate_q, WB_DAT_I[`PCLK_B_DEC_GATE],
                wmask[`PCLK_B_DEC_GATE]);
            lock_loss_reset_enable_q <= merge_bit(lock_loss_reset_enable_q, WB_DAT_I[`PCLK_B_LOLRST_EN],
                wmask[`PCLK_B_LOLRST_EN]);
            osc_loss_reset_enable_q <= merge_bit(osc_loss_reset_enable_q, WB_DAT_I[`PCLK_B_OSCRST_EN],
                wmask[`PCLK_B_OSCRST_EN]);
            if (!multiplier_write_lock_q && wmask[`PCLK_F_MULT_HI]) begin
                multiplication_factor_q <= WB_DAT_I[`PCLK_F_MULT_HI:`PCLK_F_MULT_LO];
            end
            if (!power_mode_write_lock_q && wmask[`PCLK_F_PMODE_HI]) begin
                power_mode_select_q <= WB_DAT_I[`PCLK_F_PMODE_HI:`PCLK_F_PMODE_LO];
            end
            if (!prescaler_write_lock_q && wmask[`PCLK_F_PRESC_HI]) begin
                output_prescaler_q <= WB_DAT_I[`PCLK_F_PRESC_HI:`PCLK_F_PRESC_LO];
            end
        end
    end

    // status register; wake request keeps its value through clock reset
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            pll_test_enable_q <= 1'b0;
            multiplier_write_lock_q <= 1'b0;
            power_mode_write_lock_q <= 1'b0;
            prescaler_write_lock_q <= 1'b0;
            pll_test_select_q <= 2'h0;
            pll_lock_sticky_q <= 1'b0;
            test_lock_q <= 1'b0;
            test_osc_q <= 1'b0;
        end else if (clk_rst_q) begin
            pll_test_enable_q <= 1'b0;
            multiplier_write_lock_q <= 1'b0;
            power_mode_write_lock_q <= 1'b0;
            prescaler_write_lock_q <= 1'b0;
            pll_test_select_q <= 2'h0;
            pll_lock_sticky_q <= 1'b0;
            test_lock_q <= 1'b0;
            test_osc_q <= 1'b0;
        end else begin
            if (wr && hit_stat && wmask[`PCLK_B_TEST_EN]) begin
                pll_test_enable_q <= WB_DAT_I[`PCLK_B_TEST_EN];
                // once set, a lock bit only clears by a write in freeze mode or by clock reset
                multiplier_write_lock_q <= FREEZE ? WB_DAT_I[`PCLK_B_MULT_LOCK] :
                    (multiplier_write_lock_q | WB_DAT_I[`PCLK_B_MULT_LOCK]);
                power_mode_write_lock_q <= FREEZE ? WB_DAT_I[`PCLK_B_PMODE_LOCK] :
                    (power_mode_write_lock_q | WB_DAT_I[`PCLK_B_PMODE_LOCK]);
                prescaler_write_lock_q <= FREEZE ? WB_DAT_I[`PCLK_B_PRESC_LOCK] :
                    (prescaler_write_lock_q | WB_DAT_I[`PCLK_B_PRESC_LOCK]);
            end
            if (wr && hit_stat && wmask[`PCLK_F_TSEL_HI]) begin
                pll_test_select_q <= WB_DAT_I[`PCLK_F_TSEL_HI:`PCLK_F_TSEL_LO];
            end
            if (wr && hit_stat && wmask[`PCLK_B_LOCKED] && test_mode) begin
                test_lock_q <= WB_DAT_I[`PCLK_B_LOCKED];
                test_osc_q <= WB_DAT_I[`PCLK_B_OSC_MISS];
            end
            // out-of-lock wins even against a simultaneous software set
            if (!locked_view) begin
                pll_lock_sticky_q <= 1'b0;
            end else if (wr && hit_stat && wmask[`PCLK_B_STICKY] && WB_DAT_I[`PCLK_B_STICKY]) begin
                pll_lock_sticky_q <= 1'b1;
            end
        end
    end

    // wake request: only keep-alive reset touches it, hardware set beats clear
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wake_request_q <= 1'b0;
        end else if (dec_rise) begin
            wake_request_q <= 1'b1;
        end else if (wr && hit_stat && wmask[`PCLK_B_WAKE_REQ]) begin
            wake_request_q <= WB_DAT_I[`PCLK_B_WAKE_REQ];
        end
    end

    // wishbone slave: one wait state, ack or err for one cycle
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_ERR_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= req && (hit_ctrl || hit_stat);
            WB_ERR_O <= req && !(hit_ctrl || hit_stat);
            if (req && !WB_WE_I && hit_ctrl) begin
                WB_DAT_O <= ctrl_rd;
            end else if (req && !WB_WE_I && hit_stat) begin
                WB_DAT_O <= stat_rd;
            end else begin
                WB_DAT_O <= 32'h00000000;
            end
        end
    end

    // registered control outputs
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            CLOCK_RESET <= 1'b1;
            POWER_DOWN_WAKE_OUTPUT <= 1'b0;
            SELF_CLOCKED_MODE <= 1'b0;
            DECREMENTER_CLOCK_GATE <= `PCLK_CTRL_DEC_RST;
            WAKE_PIN_EXIT <= 1'b0;
            FEEDBACK_DIVIDE <= `PCLK_MULT_BASE;
            PRESCALE_LOG2 <= 4'h0;
            POWER_MODE_SELECT <= `PCLK_PMODE_RST;
        end else begin
            CLOCK_RESET <= clk_rst_q;
            POWER_DOWN_WAKE_OUTPUT <= wake_request_q;
            SELF_CLOCKED_MODE <= osc_view;
            DECREMENTER_CLOCK_GATE <= decrementer_clock_gate_q;
            WAKE_PIN_EXIT <= IRQ_WAKE && wake_pin_mask_q;
            // top multiplier bit is don't-care; 4 plus low three bits
            FEEDBACK_DIVIDE <= `PCLK_MULT_BASE + {1'b0, multiplication_factor_q[2:0]};
            if (ONE_TO_ONE) begin
                PRESCALE_LOG2 <= 4'h0;
            end else if (output_prescaler_q > `PCLK_PRESC_MAX) begin
                PRESCALE_LOG2 <= `PCLK_PRESC_SAT;
            end else begin
                PRESCALE_LOG2 <= output_prescaler_q;
            end
            POWER_MODE_SELECT <= power_mode_select_q;
        end
    end
endmodule

// [verif/pclk_ctrl_sva.sv]
// port-level assertions for the pll clock reset and lock control block
`timescale 1ns/1ps
module pclk_ctrl_sva (
    input wire REF_CLK, // clock
    input wire NRST, // reset, active low
    input wire EXT_RESET, // pin reset
    input wire PLL_LOCKED, // lock in
    input wire OSC_LOST, // oscillator missing in
    input wire ONE_TO_ONE, // strap
    input wire DEC_MSB, // decrementer msb
    input wire IRQ_WAKE, // pin wake
    input wire WB_CYC_I, // cycle
    input wire WB_STB_I, // strobe
    input wire WB_ACK_O, // acknowledge
    input wire WB_ERR_O, // error
    input wire CLOCK_RESET, // clock reset out
    input wire POWER_DOWN_WAKE_OUTPUT, // wake out
    input wire SELF_CLOCKED_MODE, // self clocked
    input wire WAKE_PIN_EXIT, // masked wake
    input wire [3:0] FEEDBACK_DIVIDE, // divider
    input wire [3:0] PRESCALE_LOG2 // prescale
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    sequence s_take; WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O; endsequence
    // two register stages sit between calm inputs and the reset output
    sequence s_calm; (!EXT_RESET && !OSC_LOST && PLL_LOCKED) [*4]; endsequence
    chk_bus_answer: assert property (s_take |=> WB_ACK_O || WB_ERR_O)
        else $error("bus request not answered");
    chk_answer_pulse: assert property ((WB_ACK_O || WB_ERR_O) |=> !(WB_ACK_O || WB_ERR_O))
        else $error("bus answer longer than one cycle");
    chk_ext_reset: assert property (EXT_RESET |=> ##1 CLOCK_RESET)
        else $error("pin reset did not reach clock reset");
    chk_calm_release: assert property (s_calm |-> !CLOCK_RESET)
        else $error("clock reset without a cause");
    chk_osc_scm: assert property (OSC_LOST |=> SELF_CLOCKED_MODE)
        else $error("oscillator loss without self clocked mode");
    chk_wake_rise: assert property ($rose(DEC_MSB) |-> ##[1:3] POWER_DOWN_WAKE_OUTPUT)
        else $error("decrementer rise did not raise wake");
    chk_one_to_one: assert property (ONE_TO_ONE |=> PRESCALE_LOG2 == 4'h0)
        else $error("prescaler active in one to one mode");
    chk_wake_mask: assert property (!IRQ_WAKE |=> !WAKE_PIN_EXIT)
        else $error("wake exit without pin request");
    chk_field_range: assert property (FEEDBACK_DIVIDE >= 4'h4 && PRESCALE_LOG2 <= 4'ha)
        else $error("divider out of range");
endmodule
bind pclk_ctrl pclk_ctrl_sva u_sva (.REF_CLK, .NRST, .EXT_RESET, .PLL_LOCKED, .OSC_LOST, .ONE_TO_ONE, .DEC_MSB,
    .IRQ_WAKE, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .WB_ERR_O, .CLOCK_RESET, .POWER_DOWN_WAKE_OUTPUT,
    .SELF_CLOCKED_MODE, .WAKE_PIN_EXIT, .FEEDBACK_DIVIDE, .PRESCALE_LOG2);

// [verif/tb_pclk_ctrl.sv]
// self-checking bench for the pll clock reset and lock control block
`timescale 1ns/1ps
`include "pclk_defines.vh"
`define CHK(a,e) begin compares++; if ((a)!==(e)) begin bad_count++; $display("[FAIL] t=%0t %h %h",$time,a,e); end end
module tb_pclk_ctrl;
    logic REF_CLK = 0, NRST = 0, EXT_RESET = 0, PLL_LOCKED = 1, OSC_LOST = 0, PLL_BYPASS = 0, ONE_TO_ONE = 0;
    logic FREEZE = 0, DEC_MSB = 0, IRQ_WAKE = 0, WB_WE_I = 0, WB_CYC_I = 0, WB_STB_I = 0, err;
    logic [31:0] WB_ADR_I = '0, WB_DAT_I = '0, WB_DAT_O, rdat;
    logic [3:0] WB_SEL_I = '0, FEEDBACK_DIVIDE, PRESCALE_LOG2;
    logic [1:0] POWER_MODE_SELECT;
    logic WB_ACK_O, WB_ERR_O, CLOCK_RESET, POWER_DOWN_WAKE_OUTPUT, SELF_CLOCKED_MODE, DECREMENTER_CLOCK_GATE;
    logic WAKE_PIN_EXIT;
    int bad_count = 0, compares = 0, cycles = 0;
    localparam logic [31:0] CA = `PCLK_ADR_CTRL, SA = `PCLK_ADR_STAT;
    pclk_ctrl dut (.REF_CLK, .NRST, .EXT_RESET, .PLL_LOCKED, .OSC_LOST, .PLL_BYPASS, .ONE_TO_ONE, .FREEZE,
        .DEC_MSB, .IRQ_WAKE, .WB_ADR_I, .WB_DAT_I, .WB_SEL_I, .WB_WE_I, .WB_CYC_I, .WB_STB_I, .WB_DAT_O,
        .WB_ACK_O, .WB_ERR_O, .CLOCK_RESET, .POWER_DOWN_WAKE_OUTPUT, .SELF_CLOCKED_MODE,
        .DECREMENTER_CLOCK_GATE, .WAKE_PIN_EXIT, .FEEDBACK_DIVIDE, .PRESCALE_LOG2, .POWER_MODE_SELECT);
    always #2 REF_CLK = ~REF_CLK;
    task automatic print_verdict;
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            print_verdict;
        end
    end
    // request held until the answer edge; data and error taken at that edge only
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge REF_CLK);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, WB_SEL_I} <= {2'b11, we, a, d, s};
        do @(posedge REF_CLK); while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1);
        rdat = WB_DAT_O;
        err = WB_ERR_O;
        {WB_CYC_I, WB_STB_I} <= 2'b00;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        wb(0, a, '0, 4'hf);
        `CHK(rdat, e)
    endtask
    // outputs trail the registers by one clock; three edges leave margin
    task automatic look;
        repeat (3) @(posedge REF_CLK);
        #1;
    endtask
    task automatic wait_clr;
        do @(posedge REF_CLK); while (CLOCK_RESET !== 1'b0);
    endtask
    task automatic t_reset;
        rd(CA, 32'h04080000);
        rd(SA, 32'h00000002);
        look;
        `CHK({FEEDBACK_DIVIDE, PRESCALE_LOG2, POWER_MODE_SELECT, DECREMENTER_CLOCK_GATE}, 11'h281)
        wb(0, 32'h8007fc58, '0, 4'hf);
        `CHK(err, 1'b1)
        wb(1, CA, 32'hffffffff, 4'hf);
        rd(CA, 32'h1778030f);
    endtask
    task automatic t_fields;
        for (int i = 0; i < 16; i++) begin
            wb(1, CA, 32'h04000000 | 32'(i) << 19 | 32'(i % 4) << 8 | 32'(i), 4'hf);
            look;
            `CHK(FEEDBACK_DIVIDE, 4'(4 + i % 8))
            `CHK(PRESCALE_LOG2, 4'(i > 9 ? 10 : i))
            `CHK(POWER_MODE_SELECT, 2'(i % 4))
        end
    endtask
    task automatic t_gates;
        @(posedge REF_CLK);
        IRQ_WAKE <= 1;
        ONE_TO_ONE <= 1;
        wb(1, CA, 32'h00000005, 4'hf);
        look;
        `CHK({WAKE_PIN_EXIT, DECREMENTER_CLOCK_GATE, PRESCALE_LOG2}, 6'h00)
        wb(1, CA, 32'h14000005, 4'hf);
        ONE_TO_ONE <= 0;
        look;
        `CHK({WAKE_PIN_EXIT, DECREMENTER_CLOCK_GATE, PRESCALE_LOG2}, 6'h35)
    endtask
    task automatic t_locks;
        wb(1, CA, 32'h04380206, 4'hf);
        wb(1, SA, 32'h07000000, 4'h8);
        wb(1, CA, 32'h10000000, 4'hf);
        rd(CA, 32'h10380206);
        wb(1, SA, 32'h00000000, 4'h8);
        rd(SA, 32'h07000002);
        FREEZE <= 1;
        wb(1, SA, 32'h00000000, 4'h8);
        FREEZE <= 0;
        rd(SA, 32'h00000002);
    endtask
    task automatic t_sticky;
        wb(1, SA, 32'h00000004, 4'h1);
        rd(SA, 32'h00000006);
        PLL_LOCKED <= 0;
        look;
        `CHK(CLOCK_RESET, 1'b0)
        rd(SA, 32'h00000000);
        PLL_BYPASS <= 1;
        rd(SA, 32'h00000002);
        PLL_BYPASS <= 0;
        PLL_LOCKED <= 1;
        rd(SA, 32'h00000002);
    endtask
    task automatic t_wake;
        wb(1, SA, 32'h00000100, 4'h2);
        look;
        `CHK(POWER_DOWN_WAKE_OUTPUT, 1'b1)
        wb(1, SA, 32'h00000000, 4'h2);
        look;
        `CHK(POWER_DOWN_WAKE_OUTPUT, 1'b0)
        @(posedge REF_CLK);
        DEC_MSB <= 1;
        wb(1, CA, 32'h03000000, 4'hf);
        EXT_RESET <= 1;
        look;
        `CHK({CLOCK_RESET, POWER_DOWN_WAKE_OUTPUT}, 2'b11)
        @(posedge REF_CLK);
        EXT_RESET <= 0;
        wait_clr;
        rd(CA, 32'h04080000);
        rd(SA, 32'h00000102);
    endtask
    task automatic t_loss;
        wb(1, CA, 32'h02000000, 4'hf);
        PLL_LOCKED <= 0;
        look;
        `CHK(CLOCK_RESET, 1'b1)
        @(posedge REF_CLK);
        PLL_LOCKED <= 1;
        wait_clr;
        rd(CA, 32'h04080000);
        OSC_LOST <= 1;
        look;
        `CHK({CLOCK_RESET, SELF_CLOCKED_MODE}, 2'b01)
        rd(SA, 32'h00000101);
        wb(1, CA, 32'h01000000, 4'hf);
        look;
        `CHK(CLOCK_RESET, 1'b1)
        @(posedge REF_CLK);
        OSC_LOST <= 0;
        wait_clr;
        rd(CA, 32'h04080000);
    endtask
    initial begin
        repeat (2) @(posedge REF_CLK);
        NRST <= 1;
        repeat (3) @(posedge REF_CLK);
        t_reset;
        t_fields;
        t_gates;
        t_locks;
        t_sticky;
        t_wake;
        t_loss;
        print_verdict;
    end
endmodule
